// file: mre_pkg.sv
/*
  package for the move and return execution block: instruction encodings,
  operand fields, reset values and the cycle figures of each instruction.
  assumes a 14-bit instruction word delivered by the fetch stage of the core.
*/
//
// Contract
// [RL1] acc to file copy, one cycle, flags kept
// [RL2] literal into acc, one cycle, flags kept
// [RL3] irq return pops stack into pc, two cycles
// [RL4] irq return sets global irq enable bit 7
// [RL5] literal return writes its literal into acc
// [RL6] literal return pops pc, two cycles, flags kept
// [RL7] plain return pops pc, irq enable untouched
// [RL8] no-op changes nothing but pc increment
`default_nettype none

package mre_pkg;

  // instruction word geometry
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FILE_ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int STACK_DEPTH = 8;

  // opcode match patterns: (word & mask) == value
  localparam logic [13:0] MASK_MOVE_ACC_TO_FILE = 14'h3f80;
  localparam logic [13:0] CODE_MOVE_ACC_TO_FILE = 14'h0080;
  localparam logic [13:0] MASK_MOVE_LITERAL_TO_ACC = 14'h3c00;
  localparam logic [13:0] CODE_MOVE_LITERAL_TO_ACC = 14'h3000;
  localparam logic [13:0] MASK_RETURN_WITH_LITERAL = 14'h3c00;
  localparam logic [13:0] CODE_RETURN_WITH_LITERAL = 14'h3400;
  localparam logic [13:0] MASK_NO_OP = 14'h3f9f;
  localparam logic [13:0] CODE_NO_OP = 14'h0000;
  localparam logic [13:0] CODE_RETURN_FROM_IRQ = 14'h0009;
  localparam logic [13:0] CODE_RETURN_PLAIN = 14'h0008;

  // operand fields
  localparam int FILE_FIELD_LSB = 0;
  localparam int LIT_FIELD_LSB = 0;

  // interrupt control register layout and reset values
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;

  // instruction cycle counts
  localparam int CYCLES_SINGLE = 1;
  localparam int CYCLES_RETURN = 2;

  // decoded operation
  typedef enum logic [2:0]
  {
    OP_NONE = 3'h0,
    OP_MOVE_ACC_TO_FILE = 3'h1,
    OP_MOVE_LITERAL_TO_ACC = 3'h2,
    OP_NO_OP = 3'h3,
    OP_RETURN_FROM_IRQ = 3'h4,
    OP_RETURN_WITH_LITERAL = 3'h5,
    OP_RETURN_PLAIN = 3'h6
  } mre_op_t;

  // execution sequencer states, one-hot
  typedef enum logic [1:0]
  {
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } mre_state_t;

endpackage : mre_pkg

`default_nettype wire

// file: mre_file_ram.sv
/*
  file register memory: one synchronous write port and one read port whose
  data come out of a register one edge after the address.
  assumes a single clock and that write and read never need bypassing.
*/
`timescale 1ns/10ps
`default_nettype none

module mre_file_ram
  import mre_pkg::*;
#(
  parameter int ADDR_W = FILE_ADDR_W,
  parameter int WIDTH = DATA_W
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // write port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  // storage array, no reset so it maps onto plain ram
  logic [WIDTH-1:0] mem [2**ADDR_W];

  // write side
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read; a same-cycle write shows one edge later
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : mre_file_ram

`default_nettype wire

// file: mre_exec.sv
/*
  execution unit for the data moves, the no-op and the three returns of the
  8-bit core. holds the accumulator, program counter, return stack and the
  interrupt control register, and owns the file register memory.
  assumes the fetch stage offers one instruction word at a time with a valid
  strobe, and that call and interrupt logic push return addresses.
*/
`timescale 1ns/10ps
`default_nettype none

module mre_exec
  import mre_pkg::*;
#(
  parameter int STACK_LEVELS = STACK_DEPTH,
  parameter int FILE_WORDS = FILE_DEPTH
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // instruction offer from fetch
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  output logic instr_ready,
  // retirement report
  output logic instr_retire,
  output logic instr_unknown,
  // architectural state
  output logic [DATA_W-1:0] acc,
  output logic [PC_W-1:0] pc,
  output logic [7:0] irq_control_reg,
  // return stack push from call and interrupt entry
  input wire logic push_valid,
  input wire logic [PC_W-1:0] push_addr,
  // interrupt entry clears the global enable
  input wire logic irq_taken,
  // file register read port for the rest of the core
  input wire logic [FILE_ADDR_W-1:0] file_rd_addr,
  output logic [DATA_W-1:0] file_rd_data
);

  localparam int PTR_W = $clog2(STACK_LEVELS);

  // refuse shapes the logic cannot serve
  if (STACK_LEVELS < 2 || (2**PTR_W) != STACK_LEVELS)
  begin : g_bad_stack
    $error("stack levels must be a power of two, at least two");
  end
  if (FILE_WORDS != 2**FILE_ADDR_W)
  begin : g_bad_file
    $error("file words must match the 7-bit operand range");
  end

  // decode of one instruction word, used for execution and sequencing
  function automatic mre_op_t decode(input logic [INSTR_W-1:0] w);
    mre_op_t op;
    op = OP_NONE;
    if ((w & MASK_MOVE_ACC_TO_FILE) == CODE_MOVE_ACC_TO_FILE)
      op = OP_MOVE_ACC_TO_FILE;
    else if ((w & MASK_MOVE_LITERAL_TO_ACC) == CODE_MOVE_LITERAL_TO_ACC)
      op = OP_MOVE_LITERAL_TO_ACC;
    else if ((w & MASK_RETURN_WITH_LITERAL) == CODE_RETURN_WITH_LITERAL)
      op = OP_RETURN_WITH_LITERAL;
    else if (w == CODE_RETURN_FROM_IRQ)
      op = OP_RETURN_FROM_IRQ;
    else if (w == CODE_RETURN_PLAIN)
      op = OP_RETURN_PLAIN;
    else if ((w & MASK_NO_OP) == CODE_NO_OP)
      op = OP_NO_OP;
    return op;
  endfunction : decode

  // true for the two-cycle returns
  function automatic logic is_return(input mre_op_t op);
    return (op == OP_RETURN_FROM_IRQ) || (op == OP_RETURN_WITH_LITERAL) || (op == OP_RETURN_PLAIN);
  endfunction : is_return

  mre_state_t state; // sequencer state
  mre_op_t op_now; // decode of the offered word
  logic take; // instruction accepted this edge
  logic pop; // a return pops this edge
  logic [PTR_W-1:0] stack_ptr; // next free slot, wraps like the hardware stack
  logic [PC_W-1:0] stack_mem [STACK_LEVELS]; // return addresses
  logic [PC_W-1:0] stack_top_entry; // most recently pushed address
  logic [DATA_W-1:0] literal; // immediate operand field
  logic [FILE_ADDR_W-1:0] file_sel; // file operand field
  logic file_wr_en; // file memory write strobe

  assign op_now = decode(instr_word);
  assign take = instr_valid && instr_ready;
  assign pop = take && is_return(op_now);
  assign literal = instr_word[LIT_FIELD_LSB +: DATA_W];
  assign file_sel = instr_word[FILE_FIELD_LSB +: FILE_ADDR_W];
  assign stack_top_entry = stack_mem[stack_ptr - PTR_W'(1)];

  // sequencer: a return holds off the next word for its second cycle
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state <= ST_EXEC;
      instr_ready <= 1'b1;
    end
    else
    begin
      unique case (state)
        ST_EXEC:
        begin
          // [RL3] two-cycle return
          if (pop)
          begin
            state <= ST_FLUSH;
            instr_ready <= 1'b0;
          end
        end
        ST_FLUSH:
        begin
          // second cycle only holds ready low; the offered word waits
          state <= ST_EXEC;
          instr_ready <= 1'b1;
        end
        default:
        begin
          // an upset code falls back to accepting
          state <= ST_EXEC;
          instr_ready <= 1'b1;
        end
      endcase
    end
  end

  // retirement pulses, one per accepted word
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      instr_retire <= 1'b0;
      instr_unknown <= 1'b0;
    end
    else
    begin
      instr_retire <= take && (op_now != OP_NONE);
      instr_unknown <= take && (op_now == OP_NONE);
    end
  end

  // accumulator
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      acc <= ACC_RESET;
    end
    else if (take)
    begin
      // [RL2] literal into acc
      if (op_now == OP_MOVE_LITERAL_TO_ACC)
      begin
        acc <= literal;
      end
      // [RL5] literal return value
      else if (op_now == OP_RETURN_WITH_LITERAL)
      begin
        acc <= literal;
      end
    end
  end

  // program counter: step on every word, jump back on a return
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pc <= PC_RESET;
    end
    else if (pop)
    begin
      // [RL3] [RL6] [RL7] top entry into pc
      pc <= stack_top_entry;
    end
    else if (take)
    begin
      // [RL8] no-op only steps pc
      pc <= pc + PC_W'(1);
    end
  end

  // return stack pointer; a pop in the same edge as a push wins, since a
  // real core never issues both and the pc jump must stay coherent
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      stack_ptr <= '0;
    end
    else if (pop)
    begin
      // [RL7] pop the stack
      stack_ptr <= stack_ptr - PTR_W'(1);
    end
    else if (push_valid)
    begin
      stack_ptr <= stack_ptr + PTR_W'(1);
    end
  end

  // return stack contents; overflow silently overwrites the oldest slot
  always_ff @(posedge ref_clk)
  begin
    if (push_valid && !pop)
    begin
      stack_mem[stack_ptr] <= push_addr;
    end
  end

  // interrupt control register: the return set wins over an entry clear
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      irq_control_reg <= IRQ_CONTROL_RESET;
    end
    else if (pop && (op_now == OP_RETURN_FROM_IRQ))
    begin
      // [RL4] re-enable interrupts
      irq_control_reg[GLOBAL_IRQ_ENABLE_BIT] <= 1'b1;
    end
    else if (irq_taken)
    begin
      irq_control_reg[GLOBAL_IRQ_ENABLE_BIT] <= 1'b0;
    end
  end

  // [RL1] acc copied to file
  assign file_wr_en = take && (op_now == OP_MOVE_ACC_TO_FILE);

  // file register memory, written with the acc value before the edge
  mre_file_ram #(
    .ADDR_W(FILE_ADDR_W),
    .WIDTH(DATA_W)
  ) u_file_ram (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .wr_en(file_wr_en),
    .wr_addr(file_sel),
    .wr_data(acc),
    .rd_addr(file_rd_addr),
    .rd_data(file_rd_data)
  );

endmodule : mre_exec

`default_nettype wire

// file: mre_exec_monitor.sv
/*
  checker for mre_exec: timing and effect of moves, no-op and returns.
  assumes it is bound to mre_exec and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none

module mre_exec_monitor
  import mre_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // instruction port
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic instr_ready,
  input wire logic instr_retire,
  // state and interrupt entry
  input wire logic [DATA_W-1:0] acc,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0] irq_control_reg,
  input wire logic irq_taken
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // decode of the word being taken
  logic take, lit, rlit, ret, nop, tofile;
  assign take = instr_valid && instr_ready;
  assign lit = (instr_word & MASK_MOVE_LITERAL_TO_ACC) == CODE_MOVE_LITERAL_TO_ACC;
  assign rlit = (instr_word & MASK_RETURN_WITH_LITERAL) == CODE_RETURN_WITH_LITERAL;
  assign nop = (instr_word & MASK_NO_OP) == CODE_NO_OP;
  assign tofile = (instr_word & MASK_MOVE_ACC_TO_FILE) == CODE_MOVE_ACC_TO_FILE;
  assign ret = rlit || instr_word == CODE_RETURN_FROM_IRQ || instr_word == CODE_RETURN_PLAIN;

  // second return cycle: one stall, then open again
  sequence s_gap;
    !instr_ready ##1 instr_ready;
  endsequence

  property p_lit;
    take && lit |=> acc == $past(instr_word[7:0]) && instr_retire;
  endproperty
  a_lit: assert property (p_lit) else $error("literal load wrong");

  property p_tofile;
    take && tofile |=> pc == $past(pc) + 13'h1 && acc == $past(acc) && instr_retire;
  endproperty
  a_tofile: assert property (p_tofile) else $error("file move wrong");

  property p_single;
    take && !ret |=> instr_ready;
  endproperty
  a_single: assert property (p_single) else $error("single op stalled");

  property p_nop;
    take && nop && !irq_taken |=> pc == $past(pc) + 13'h1 && acc == $past(acc)
      && irq_control_reg == $past(irq_control_reg);
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");

  property p_stall;
    !instr_ready |=> pc == $past(pc) && acc == $past(acc);
  endproperty
  a_stall: assert property (p_stall) else $error("stall moved state");

  property p_rfi;
    take && instr_word == CODE_RETURN_FROM_IRQ |=> irq_control_reg[GLOBAL_IRQ_ENABLE_BIT] ##0 s_gap;
  endproperty
  a_rfi: assert property (p_rfi) else $error("irq return wrong");

  property p_rlit;
    take && rlit |=> acc == $past(instr_word[7:0]) ##0 s_gap;
  endproperty
  a_rlit: assert property (p_rlit) else $error("literal return wrong");

  property p_plain;
    take && instr_word == CODE_RETURN_PLAIN && !irq_taken |=> irq_control_reg == $past(irq_control_reg) ##0 s_gap;
  endproperty
  a_plain: assert property (p_plain) else $error("plain return wrong");
endmodule : mre_exec_monitor

bind mre_exec mre_exec_monitor u_mon (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .instr_ready(instr_ready),
  .instr_retire(instr_retire),
  .acc(acc),
  .pc(pc),
  .irq_control_reg(irq_control_reg),
  .irq_taken(irq_taken)
);

`default_nettype wire

// file: mre_exec_test.sv
/*
  self-checking bench for mre_exec: moves, no-ops and the three returns.
  assumes the pc steps by one per single-cycle word and returns stall once.
*/
`timescale 1ns/10ps
`default_nettype none

module mre_exec_test
  import mre_pkg::*;
;
  // stimulus, all given a value at time zero
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [INSTR_W-1:0] instr_word = 14'h0000;
  logic push_valid = 1'b0;
  logic [PC_W-1:0] push_addr = 13'h0000;
  logic irq_taken = 1'b0;
  logic [FILE_ADDR_W-1:0] file_rd_addr = 7'h00;
  // observed outputs
  logic instr_ready, instr_retire, instr_unknown;
  logic [DATA_W-1:0] acc, file_rd_data;
  logic [PC_W-1:0] pc;
  logic [7:0] irq_control_reg;
  int failures = 0;
  int checked = 0;

  mre_exec uut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .instr_ready(instr_ready),
    .instr_retire(instr_retire),
    .instr_unknown(instr_unknown),
    .acc(acc),
    .pc(pc),
    .irq_control_reg(irq_control_reg),
    .push_valid(push_valid),
    .push_addr(push_addr),
    .irq_taken(irq_taken),
    .file_rd_addr(file_rd_addr),
    .file_rd_data(file_rd_data)
  );

  // 100 MHz clock
  initial forever #5 ref_clk = ~ref_clk;

  task check(input logic [12:0] seen, input logic [12:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check

  task tally_and_finish;
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // offer a word, held until an edge with ready high takes it
  task issue(input logic [13:0] w);
    instr_valid <= 1'b1;
    instr_word <= w;
    do @(posedge ref_clk); while (instr_ready !== 1'b1);
  endtask : issue

  // drop valid and step into the cycle after the take
  task idle;
    instr_valid <= 1'b0;
    @(posedge ref_clk);
  endtask : idle

  // back-to-back loads and file moves at both address ends
  task t_moves;
    for (int i = 0; i < 2; i++)
    begin
      issue(CODE_MOVE_LITERAL_TO_ACC | (i ? 14'h005a : 14'h00ff));
      issue(CODE_MOVE_ACC_TO_FILE | (i ? 14'h007f : 14'h0000));
    end
    idle;
    check(13'(acc), 13'h005a);
    check(pc, 13'h0004);
    file_rd_addr <= 7'h00;
    @(posedge ref_clk);
    file_rd_addr <= 7'h7f;
    @(posedge ref_clk);
    check(13'(file_rd_data), 13'h00ff);
    @(posedge ref_clk);
    check(13'(file_rd_data), 13'h005a);
  endtask : t_moves

  // two no-op forms only step the pc
  task t_nop;
    issue(CODE_NO_OP);
    issue(14'h0060);
    idle;
    check(pc, 13'h0006);
    check(13'(acc), 13'h005a);
  endtask : t_nop

  // three pushes, then each return pops one in reverse order
  task t_returns;
    push_valid <= 1'b1;
    push_addr <= 13'h1abc;
    @(posedge ref_clk);
    push_addr <= 13'h0123;
    @(posedge ref_clk);
    push_addr <= 13'h1fff;
    @(posedge ref_clk);
    push_valid <= 1'b0;
    issue(CODE_RETURN_FROM_IRQ);
    idle;
    check(pc, 13'h1fff);
    check(13'(irq_control_reg), 13'h0080);
    irq_taken <= 1'b1;
    @(posedge ref_clk);
    irq_taken <= 1'b0;
    // a literal offered in the stall cycle must wait
    issue(CODE_RETURN_PLAIN);
    issue(CODE_MOVE_LITERAL_TO_ACC | 14'h0011);
    idle;
    check(pc, 13'h0124);
    check(13'(acc), 13'h0011);
    check(13'(irq_control_reg), 13'h0000);
    issue(CODE_RETURN_WITH_LITERAL | 14'h003c);
    idle;
    check(13'(acc), 13'h003c);
    check(pc, 13'h1abc);
    check(13'(instr_ready), 13'h0000);
  endtask : t_returns

  // retire and unknown pulses, then a pop racing a push and an irq entry
  task t_races;
    // undecodable word steps the pc and flags itself
    issue(14'h0001);
    idle;
    check(13'(instr_unknown), 13'h0001);
    check(13'(instr_retire), 13'h0000);
    check(pc, 13'h1abd);
    issue(CODE_NO_OP);
    idle;
    check(13'(instr_retire), 13'h0001);
    check(13'(instr_unknown), 13'h0000);
    // two entries, then the irq return meets a push and an entry clear
    push_valid <= 1'b1;
    push_addr <= 13'h0555;
    @(posedge ref_clk);
    push_addr <= 13'h0666;
    @(posedge ref_clk);
    push_addr <= 13'h0777;
    irq_taken <= 1'b1;
    issue(CODE_RETURN_FROM_IRQ);
    push_valid <= 1'b0;
    irq_taken <= 1'b0;
    idle;
    check(pc, 13'h0666);
    check(13'(irq_control_reg), 13'h0080);
    // the dropped push must not have moved the pointer
    issue(CODE_RETURN_PLAIN);
    idle;
    check(pc, 13'h0555);
    check(13'(irq_control_reg), 13'h0080);
    // let the stall cycle close before the run ends
    @(posedge ref_clk);
  endtask : t_races

  // reset, run every scenario, then report
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check(pc, 13'h0000);
    t_moves;
    t_nop;
    t_returns;
    t_races;
    tally_and_finish;
  end

  // watchdog well beyond the 39 cycles used
  initial
  begin
    #20000;
    failures++;
    tally_and_finish;
  end
endmodule : mre_exec_test

`default_nettype wire
